// ---- hw/vps_top.sv ----
// Voltage PWM amplitude scaling, chopper mode switch and open-load flags.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
// Operation
// R1 - Without autoscale, amplitude equals the fixed amplitude setting unchanged.
// R2 - Scale multiplies a sine of peak 248/256, so voltage is supply*scale/264.
// R3 - Voltage chopper below switch velocity, current chopper above it.
// R4 - Host sets both velocity limits above ramp top for voltage-only use.
// R5 - Regulated amplitude is frozen outside voltage mode and resumed later.
// R6 - Host keeps the motor still when first enabling regulated voltage mode.
// R7 - Host should wait at least 128 chopper periods at standstill.
// R8 - After stall or short, host clears flags and restarts from zero.
// R9 - Per-coil open flag shows whether nominal current is reachable.
// R10 - An interrupted coil keeps its open flag continuously set.
// R11 - Both open flags set when full current missed over recent full steps.
// R12 - Gain above 1 measures only the larger-target coil.
// R13 - Host should test open load before entering voltage mode.
// R14 - The regulated amplitude is readable by software.
// R15 - Voltage mode only below the lower of the two velocity limits.
// R16 - Gain 0 disables voltage mode; 1 to 15 set the loop gradient.
// R17 - Chopper rate select divides the clock by 2/1024, 2/683, 2/512, 2/410.
module vps_top (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [22:0] velocity_i,
   input wire logic [7:0] target_a_i,
   input wire logic [7:0] target_b_i,
   input wire logic [7:0] meas_a_i,
   input wire logic [7:0] meas_b_i,
   input wire logic [7:0] sine_a_i,
   input wire logic [7:0] sine_b_i,
   input wire logic fullstep_i,
   output logic [31:0] rd_data_o,
   output logic [7:0] pwm_scale_o,
   output logic [7:0] duty_a_o,
   output logic [7:0] duty_b_o,
   output logic volt_mode_o,
   output logic coil_a_open_flag_o,
   output logic coil_b_open_flag_o,
   output logic irq_o
);

   typedef struct packed {
      logic autoscale;
      logic [3:0] regulation_gain;
      logic [1:0] chop_rate_select;
      logic [7:0] fixed_amplitude_setting;
      logic [22:0] chopper_switch_velocity;
      logic [22:0] upper_velocity_limit;
      logic [2:0] int_st;
      logic [2:0] int_mask;
      logic [7:0] scale;
      vps_pkg::vps_mode_t mode;
      logic volt;
      logic open_a;
      logic open_b;
      logic reached;
      logic [2:0] fail_cnt;
      logic [7:0] duty_a;
      logic [7:0] duty_b;
      logic [31:0] rdata;
      logic irq;
   } vps_state_t;

   vps_state_t q_reg;
   vps_state_t q_next;
   logic [1:0] rst_sync_reg;
   logic rst_n;

   // Release the asynchronous reset through two flip-flops.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   vps_pwm_if pwm_link ();

   vps_pwm_timer u_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .pwm(pwm_link.timer)
   );

   assign pwm_link.rate_sel = q_reg.chop_rate_select; // R17

   // Apply the amplitude scale to a sine value clamped to the table peak.
   function automatic logic [7:0] scale_sine(input logic [7:0] s, input logic [7:0] sc);
      logic [7:0] c;
      logic [15:0] p;
      c = (s > vps_pkg::SINE_PEAK) ? vps_pkg::SINE_PEAK : s;
      p = c * sc;
      scale_sine = p[15:8];
   endfunction

   // Saturating add of a signed step onto an unsigned 8-bit amplitude.
   function automatic logic [7:0] sat_add(input logic [7:0] a, input logic signed [13:0] d);
      logic signed [14:0] r;
      r = $signed({7'd0, a}) + 15'(d);
      if (r < 0) begin
         sat_add = 8'h00;
      end else if (r > 15'sd255) begin
         sat_add = 8'hFF;
      end else begin
         sat_add = r[7:0];
      end
   endfunction

   logic [22:0] vlim;
   logic [8:0] reg_tgt;
   logic [8:0] reg_meas;
   logic signed [9:0] err;
   logic signed [13:0] step;
   logic reach_a;
   logic reach_b;
   logic volt_now;
   logic [2:0] events;

   // Mode switch, regulator, open-load flags, register port and interrupt.
   always_comb begin
      q_next = q_reg;
      q_next.rdata = 32'h0000_0000;
      events = 3'b000;

      // The lower velocity limit bounds voltage mode.
      vlim = (q_reg.chopper_switch_velocity < q_reg.upper_velocity_limit) ?
             q_reg.chopper_switch_velocity : q_reg.upper_velocity_limit; // R15
      if (q_reg.regulation_gain == 4'h0) begin
         q_next.mode = vps_pkg::MODE_OFF; // R16
      end else if (velocity_i < vlim) begin
         q_next.mode = vps_pkg::MODE_VOLT; // R3
      end else begin
         q_next.mode = vps_pkg::MODE_CURRENT; // R3
      end
      // Registered copy of the mode decode so that the pin comes from a flip-flop.
      q_next.volt = (q_next.mode == vps_pkg::MODE_VOLT);
      volt_now = (q_reg.mode == vps_pkg::MODE_VOLT);

      // Gain above 1 regulates on the coil with the larger target only.
      if (q_reg.regulation_gain > 4'h1) begin
         if (target_a_i >= target_b_i) begin
            reg_tgt = {1'b0, target_a_i}; // R12
            reg_meas = {1'b0, meas_a_i};
         end else begin
            reg_tgt = {1'b0, target_b_i}; // R12
            reg_meas = {1'b0, meas_b_i};
         end
      end else begin
         reg_tgt = ({1'b0, target_a_i} + {1'b0, target_b_i}) >> 1;
         reg_meas = ({1'b0, meas_a_i} + {1'b0, meas_b_i}) >> 1;
      end
      err = $signed({1'b0, reg_tgt}) - $signed({1'b0, reg_meas});
      step = (14'(err) * $signed({10'd0, q_reg.regulation_gain})) >>> 4; // R16
      if (step == 14'sd0 && err != 10'sd0) begin
         step = (err < 0) ? -14'sd1 : 14'sd1;
      end

      // Fixed scaling copies the setting; autoscale only moves in voltage mode.
      if (!q_reg.autoscale) begin
         q_next.scale = q_reg.fixed_amplitude_setting; // R1
      end else if (volt_now && pwm_link.tick && reg_tgt != 9'd0) begin // R5
         q_next.scale = sat_add(q_reg.scale, step);
      end
      // Outside voltage mode the regulated value simply stays put.

      q_next.duty_a = scale_sine(sine_a_i, q_reg.scale); // R2
      q_next.duty_b = scale_sine(sine_b_i, q_reg.scale); // R2

      // Each chopper period in voltage mode tells whether each coil reaches its nominal current.
      reach_a = (meas_a_i >= target_a_i);
      reach_b = (meas_b_i >= target_b_i);
      if (volt_now && pwm_link.tick) begin
         q_next.open_a = !reach_a; // R9 R10
         q_next.open_b = !reach_b; // R9 R10
         if (reg_meas >= reg_tgt) begin
            q_next.reached = 1'b1;
         end
      end
      if (volt_now && fullstep_i) begin
         q_next.reached = 1'b0;
         if (q_reg.reached) begin
            q_next.fail_cnt = 3'd0;
         end else if (q_reg.fail_cnt != vps_pkg::FAIL_STEPS) begin
            q_next.fail_cnt = q_reg.fail_cnt + 3'd1;
         end
      end
      if (!volt_now) begin
         q_next.fail_cnt = 3'd0;
         q_next.open_a = 1'b0;
         q_next.open_b = 1'b0;
      end else if (q_reg.fail_cnt == vps_pkg::FAIL_STEPS) begin
         q_next.open_a = 1'b1; // R11
         q_next.open_b = 1'b1; // R11
      end

      events[vps_pkg::INT_OPEN_A] = q_next.open_a && !q_reg.open_a;
      events[vps_pkg::INT_OPEN_B] = q_next.open_b && !q_reg.open_b;
      events[vps_pkg::INT_MODE] = (q_next.mode != q_reg.mode);

      // Register writes; a write of one clears a status bit.
      if (wr_i) begin
         case (addr_i)
            vps_pkg::ADDR_CTRL: begin
               q_next.autoscale = wr_data_i[vps_pkg::CTRL_AUTO_BIT];
               q_next.regulation_gain = wr_data_i[vps_pkg::CTRL_GAIN_LSB +: 4];
               q_next.chop_rate_select = wr_data_i[vps_pkg::CTRL_RATE_LSB +: 2];
            end
            vps_pkg::ADDR_FIXED: q_next.fixed_amplitude_setting = wr_data_i[7:0];
            vps_pkg::ADDR_SW_VEL: q_next.chopper_switch_velocity = wr_data_i[22:0];
            vps_pkg::ADDR_HI_VEL: q_next.upper_velocity_limit = wr_data_i[22:0];
            vps_pkg::ADDR_INT_ST: q_next.int_st = q_reg.int_st & ~wr_data_i[2:0];
            vps_pkg::ADDR_INT_MASK: q_next.int_mask = wr_data_i[2:0];
            default: q_next.int_mask = q_next.int_mask;
         endcase
      end
      // A new event wins over a clear in the same cycle.
      q_next.int_st = q_next.int_st | events;
      q_next.irq = |(q_next.int_st & q_next.int_mask);

      // Read data appear in the cycle after the strobe; unmapped reads give zero.
      if (rd_i) begin
         case (addr_i)
            vps_pkg::ADDR_CTRL: begin
               q_next.rdata[vps_pkg::CTRL_AUTO_BIT] = q_reg.autoscale;
               q_next.rdata[vps_pkg::CTRL_GAIN_LSB +: 4] = q_reg.regulation_gain;
               q_next.rdata[vps_pkg::CTRL_RATE_LSB +: 2] = q_reg.chop_rate_select;
            end
            vps_pkg::ADDR_FIXED: q_next.rdata[7:0] = q_reg.fixed_amplitude_setting;
            vps_pkg::ADDR_SW_VEL: q_next.rdata[22:0] = q_reg.chopper_switch_velocity;
            vps_pkg::ADDR_HI_VEL: q_next.rdata[22:0] = q_reg.upper_velocity_limit;
            vps_pkg::ADDR_STATUS: begin
               q_next.rdata[vps_pkg::STAT_SCALE_LSB +: 8] = q_reg.scale; // R14
               q_next.rdata[vps_pkg::STAT_VOLT_BIT] = volt_now;
               q_next.rdata[vps_pkg::STAT_OPEN_A_BIT] = q_reg.open_a;
               q_next.rdata[vps_pkg::STAT_OPEN_B_BIT] = q_reg.open_b;
               q_next.rdata[vps_pkg::STAT_MODE_LSB +: 2] = q_reg.mode;
            end
            vps_pkg::ADDR_INT_ST: q_next.rdata[2:0] = q_reg.int_st;
            vps_pkg::ADDR_INT_MASK: q_next.rdata[2:0] = q_reg.int_mask;
            default: q_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // One register for all state except the reset synchronizer; clock enable low freezes it.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= '0;
         q_reg.autoscale <= vps_pkg::RST_AUTO;
         q_reg.regulation_gain <= vps_pkg::RST_GAIN;
         q_reg.chop_rate_select <= vps_pkg::RST_RATE;
         q_reg.fixed_amplitude_setting <= vps_pkg::RST_FIXED;
         q_reg.chopper_switch_velocity <= vps_pkg::RST_SW_VEL;
         q_reg.upper_velocity_limit <= vps_pkg::RST_HI_VEL;
         q_reg.mode <= vps_pkg::MODE_OFF;
      end else if (ce_i) begin
         q_reg <= q_next;
      end
   end

   assign rd_data_o = q_reg.rdata;
   assign pwm_scale_o = q_reg.scale;
   assign duty_a_o = q_reg.duty_a;
   assign duty_b_o = q_reg.duty_b;
   assign volt_mode_o = q_reg.volt;
   assign coil_a_open_flag_o = q_reg.open_a;
   assign coil_b_open_flag_o = q_reg.open_b;
   assign irq_o = q_reg.irq;

   a_fixed_amp: assert property (@(posedge clk_i) disable iff (!rst_n) // R1
      (ce_i && !q_reg.autoscale) |=> pwm_scale_o == $past(q_reg.fixed_amplitude_setting))
      else $error("fixed amplitude not applied");

   a_duty_peak: assert property (@(posedge clk_i) disable iff (!rst_n) // R2
      (ce_i && sine_a_i == 8'hFF) |=> duty_a_o == 8'((16'(vps_pkg::SINE_PEAK)
         * 16'($past(pwm_scale_o))) >> 8))
      else $error("sine peak scaling wrong");

   a_mode_above: assert property (@(posedge clk_i) disable iff (!rst_n) // R3
      (ce_i && velocity_i >= q_reg.chopper_switch_velocity) |=> !volt_mode_o)
      else $error("voltage mode above switch velocity");

   a_mode_limit: assert property (@(posedge clk_i) disable iff (!rst_n) // R15
      (ce_i && q_reg.regulation_gain != 4'h0 && velocity_i < q_reg.chopper_switch_velocity
         && velocity_i < q_reg.upper_velocity_limit) |=> volt_mode_o)
      else $error("voltage mode missing below limits");

   a_scale_freeze: assert property (@(posedge clk_i) disable iff (!rst_n) // R5
      (ce_i && q_reg.autoscale && !volt_mode_o && !(wr_i && addr_i == vps_pkg::ADDR_CTRL))
      |=> $stable(pwm_scale_o))
      else $error("regulated amplitude moved outside voltage mode");

   a_gain_zero: assert property (@(posedge clk_i) disable iff (!rst_n) // R16
      (ce_i && q_reg.regulation_gain == 4'h0) |=> q_reg.mode == vps_pkg::MODE_OFF)
      else $error("voltage mode with zero gain");

   a_open_coil: assert property (@(posedge clk_i) disable iff (!rst_n) // R10
      (ce_i && volt_mode_o && pwm_link.tick && meas_a_i < target_a_i) |=> coil_a_open_flag_o)
      else $error("open coil not flagged");

   a_open_both: assert property (@(posedge clk_i) disable iff (!rst_n) // R11
      (ce_i && volt_mode_o && q_reg.fail_cnt == vps_pkg::FAIL_STEPS)
      |=> coil_a_open_flag_o && coil_b_open_flag_o)
      else $error("both open flags not set");

   a_scale_read: assert property (@(posedge clk_i) disable iff (!rst_n) // R14
      (ce_i && rd_i && addr_i == vps_pkg::ADDR_STATUS) |=> rd_data_o[7:0] == $past(pwm_scale_o))
      else $error("amplitude readback wrong");

endmodule

// ---- hw/vps_pkg.sv ----
// Package with the constants and types of the voltage PWM scaling block.
package vps_pkg;

   // Register offsets on the plain register port.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FIXED = 8'h04;
   localparam logic [7:0] ADDR_SW_VEL = 8'h08;
   localparam logic [7:0] ADDR_HI_VEL = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_INT_ST = 8'h14;
   localparam logic [7:0] ADDR_INT_MASK = 8'h18;

   // Control register field positions.
   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_GAIN_LSB = 1;
   localparam int CTRL_RATE_LSB = 5;

   // Status register field positions.
   localparam int STAT_SCALE_LSB = 0;
   localparam int STAT_VOLT_BIT = 8;
   localparam int STAT_OPEN_A_BIT = 9;
   localparam int STAT_OPEN_B_BIT = 10;
   localparam int STAT_MODE_LSB = 11;

   // Interrupt status and mask bit positions.
   localparam int INT_OPEN_A = 0;
   localparam int INT_OPEN_B = 1;
   localparam int INT_MODE = 2;

   // Reset values.
   localparam logic RST_AUTO = 1'b0;
   localparam logic [3:0] RST_GAIN = 4'h0;
   localparam logic [1:0] RST_RATE = 2'h0;
   localparam logic [7:0] RST_FIXED = 8'h80;
   localparam logic [22:0] RST_SW_VEL = 23'h00_0000;
   localparam logic [22:0] RST_HI_VEL = 23'h7F_FFFF;

   // Sine table peak and the full steps allowed without reaching full current.
   localparam logic [7:0] SINE_PEAK = 8'hF8;
   localparam logic [2:0] FAIL_STEPS = 3'h4;

   // Double-period lengths in clocks for the four chopper rate settings.
   localparam logic [10:0] PER_RATE0 = 11'h400;
   localparam logic [10:0] PER_RATE1 = 11'h2AB;
   localparam logic [10:0] PER_RATE2 = 11'h200;
   localparam logic [10:0] PER_RATE3 = 11'h19A;

   // Chopper selection of the coil drive.
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_VOLT,
      MODE_CURRENT
   } vps_mode_t;

endpackage

// ---- hw/vps_pwm_if.sv ----
// Interface between the core and its chopper period timer.
`timescale 1ns/100ps
interface vps_pwm_if;
   logic [1:0] rate_sel;
   logic tick;

   modport timer (input rate_sel, output tick);
   modport core (output rate_sel, input tick);
endinterface

// ---- hw/vps_pwm_timer.sv ----
// Chopper period timer: one tick per voltage PWM period.
`timescale 1ns/100ps
module vps_pwm_timer (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   vps_pwm_if.timer pwm
);

   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } vps_timer_state_t;

   vps_timer_state_t q_reg;
   vps_timer_state_t q_next;

   // Map the rate setting to a double-period length in clocks.
   function automatic logic [10:0] double_period(input logic [1:0] sel);
      case (sel)
         2'd0: double_period = vps_pkg::PER_RATE0;
         2'd1: double_period = vps_pkg::PER_RATE1;
         2'd2: double_period = vps_pkg::PER_RATE2;
         default: double_period = vps_pkg::PER_RATE3;
      endcase
   endfunction

   logic [10:0] dper;

   // Two ticks per double period give the odd divider 683 its 2/683 rate.
   always_comb begin
      dper = double_period(pwm.rate_sel); // R17
      q_next = q_reg;
      q_next.tick = 1'b0;
      if ({1'b0, q_reg.cnt} >= dper - 11'd1) begin
         q_next.cnt = 10'd0;
         q_next.tick = 1'b1;
      end else begin
         q_next.cnt = q_reg.cnt + 10'd1;
         if ({1'b0, q_reg.cnt} == (dper >> 1) - 11'd1) begin
            q_next.tick = 1'b1;
         end
      end
   end

   // Clock enable low freezes the counter and holds the tick.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_reg <= '0;
      end else if (ce_i) begin
         q_reg <= q_next;
      end
   end

   assign pwm.tick = q_reg.tick;

   // Ticks are never adjacent while the rate setting holds, since the shortest half period is 205 clocks.
   a_tick_spacing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (q_reg.tick && ce_i) |=> !q_reg.tick) // R17
      else $error("chopper ticks too close");

endmodule

// ---- test/vps_coil_model.sv ----
// Behavioural model of the two motor coils seen through the current sense path.
`timescale 1ns/100ps
module vps_coil_model (
   input wire logic clk_i,
   input wire logic [7:0] duty_a_i,
   input wire logic [7:0] duty_b_i,
   input wire logic open_a_i,
   input wire logic open_b_i,
   output logic [7:0] meas_a_o,
   output logic [7:0] meas_b_o
);
   // A healthy coil follows its duty one clock later; a broken coil carries no current at all.
   always_ff @(posedge clk_i) begin
      meas_a_o <= open_a_i ? 8'h00 : duty_a_i;
      meas_b_o <= open_b_i ? 8'h00 : duty_b_i;
   end
endmodule

// ---- test/vps_top_tb.sv ----
// Self-checking bench of the voltage PWM scaling block against a register and duty model.
`timescale 1ns/100ps
module vps_top_tb;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wr_data_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [22:0] velocity_i = 23'h00_0000;
   logic [7:0] target_a_i = 8'h10;
   logic [7:0] target_b_i = 8'h10;
   logic [7:0] sine_a_i = 8'hF8;
   logic [7:0] sine_b_i = 8'hF8;
   logic fullstep_i = 1'b0;
   logic open_a = 1'b0;
   logic open_b = 1'b0;
   logic [7:0] meas_a, meas_b, pwm_scale_o, duty_a_o, duty_b_o;
   logic [31:0] rd_data_o;
   logic volt_mode_o, coil_a_open_flag_o, coil_b_open_flag_o, irq_o;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   int mdl[8];
   int msk[8] = '{32'h7F, 32'hFF, 32'h7F_FFFF, 32'h7F_FFFF, 0, 0, 32'h7, 0};
   int per[4] = '{1024, 683, 512, 410};
   int vel[6] = '{10, 999, 1000, 499, 500, 12};
   int t1, t2, lows;
   logic [7:0] f, held;
   logic [31:0] d;

   vps_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .velocity_i(velocity_i),
      .target_a_i(target_a_i), .target_b_i(target_b_i), .meas_a_i(meas_a), .meas_b_i(meas_b),
      .sine_a_i(sine_a_i), .sine_b_i(sine_b_i), .fullstep_i(fullstep_i), .rd_data_o(rd_data_o),
      .pwm_scale_o(pwm_scale_o), .duty_a_o(duty_a_o), .duty_b_o(duty_b_o),
      .volt_mode_o(volt_mode_o), .coil_a_open_flag_o(coil_a_open_flag_o),
      .coil_b_open_flag_o(coil_b_open_flag_o), .irq_o(irq_o));

   vps_coil_model coils (.clk_i(clk_i), .duty_a_i(duty_a_o), .duty_b_i(duty_b_o),
      .open_a_i(open_a), .open_b_i(open_b), .meas_a_o(meas_a), .meas_b_o(meas_b));

   // Free-running 125 MHz clock.
   initial begin
      forever #4 clk_i = ~clk_i;
   end

   // Cycle ceiling so that a stuck handshake cannot hang the run.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 90000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Write cycle; the model mirrors only the writable bits.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      if (ce_i && a[1:0] == 2'b00 && a < 8'h20) mdl[a >> 2] = v & msk[a >> 2];
   endtask

   // Read cycle; data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      v = rd_data_o;
   endtask

   // Counts cycles until the scale output next changes.
   task automatic wait_chg(output int n);
      logic [7:0] p;
      p = pwm_scale_o;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (pwm_scale_o === p && n < 3000);
   endtask

   task automatic pulse_steps(input int n);
      repeat (n) begin
         cyc(99);
         fullstep_i <= 1'b1;
         @(posedge clk_i);
         fullstep_i <= 1'b0;
      end
   endtask

   initial begin
      void'($urandom(32'hc9ab));
      mdl = '{0, 32'h80, 0, 32'h7F_FFFF, 0, 0, 0, 0};
      cyc(4);
      reset_n_i <= 1'b1;
      cyc(4);
      // Reset values, then an unmapped address.
      for (int i = 0; i < 8; i++) begin
         if (i == 4) continue;
         rd(8'(i * 4), d);
         chk("reset reg", mdl[i], d);
      end
      chk("reset scale", 32'h80, pwm_scale_o);
      $display("test reset done");
      // Fixed amplitude with random settings and sine values beyond the peak.
      wr(vps_pkg::ADDR_CTRL, 32'h0000_0002);
      for (int i = 0; i < 6; i++) begin
         f = 8'($urandom);
         sine_a_i <= 8'($urandom);
         sine_b_i <= 8'(248 + i);
         wr(vps_pkg::ADDR_FIXED, f);
         cyc(3);
         chk("fixed scale", f, pwm_scale_o);
         chk("duty a", ((sine_a_i > 248 ? 248 : sine_a_i) * f) >> 8, duty_a_o);
         chk("duty b", ((sine_b_i > 248 ? 248 : sine_b_i) * f) >> 8, duty_b_o);
         rd(vps_pkg::ADDR_FIXED, d);
         chk("fixed reg", mdl[1], d);
      end
      $display("test fixed done");
      // Mode selection table: gain, switch velocity, upper limit, velocity.
      for (int i = 0; i < 6; i++) begin
         int g, sw, hi, v, m;
         g = (i == 0) ? 0 : (i == 5 ? 15 : 1);
         sw = (i < 3) ? 1000 : 2000;
         hi = (i < 3) ? 2000 : 500;
         v = vel[i];
         m = (g == 0) ? 0 : (v < (sw < hi ? sw : hi) ? 1 : 2);
         wr(vps_pkg::ADDR_CTRL, g << 1);
         wr(vps_pkg::ADDR_SW_VEL, sw);
         wr(vps_pkg::ADDR_HI_VEL, hi);
         velocity_i <= 23'(v);
         cyc(3);
         chk("volt mode", m == 1, volt_mode_o);
         rd(vps_pkg::ADDR_STATUS, d);
         chk("mode field", m, d[12:11]);
      end
      $display("test mode done");
      // Both velocity limits above the ramp top keep the drive in voltage mode.
      wr(vps_pkg::ADDR_FIXED, 32'h0000_0010);
      wr(vps_pkg::ADDR_SW_VEL, 32'h0000_4000);
      wr(vps_pkg::ADDR_HI_VEL, 32'h0000_8000);
      velocity_i <= 23'h00_0000;
      // Coils break here on purpose; a host would have screened them in current mode first.
      open_a <= 1'b1;
      open_b <= 1'b1;
      // Open coils make every tick step the scale by one, so change spacing shows the period.
      for (int r = 0; r < 4; r++) begin
         wr(vps_pkg::ADDR_CTRL, 32'h0000_0003 | (r << 5));
         wait_chg(t1);
         wait_chg(t1);
         wait_chg(t2);
         chk("chop period", per[r], t1 + t2);
      end
      $display("test rate done");
      // Larger target on the healthy coil B; the open coil A must not drive the loop.
      open_b <= 1'b0;
      target_a_i <= 8'h64;
      target_b_i <= 8'h78;
      wr(vps_pkg::ADDR_CTRL, 32'h0000_0069);
      cyc(128 * 410);
      chk("gain above one", 1, pwm_scale_o > 8'h70 && pwm_scale_o < 8'h88);
      rd(vps_pkg::ADDR_STATUS, d);
      chk("status scale", 1, d[7:0] > 8'h70 && d[7:0] < 8'h88);
      lows = 0;
      for (int i = 0; i < 1000; i++) begin
         cyc(1);
         if (coil_a_open_flag_o !== 1'b1) lows++;
      end
      chk("open a held", 0, lows);
      $display("test open coil done");
      // Above the switch velocity the regulated value freezes and is resumed on return.
      held = pwm_scale_o;
      velocity_i <= 23'h00_5000;
      cyc(4);
      chk("current mode", 0, volt_mode_o);
      cyc(2000);
      chk("frozen scale", held, pwm_scale_o);
      chk("flags off", 0, {coil_a_open_flag_o, coil_b_open_flag_o});
      velocity_i <= 23'h00_0000;
      t1 = 0;
      while (volt_mode_o !== 1'b1 && t1 < 10) begin
         cyc(1);
         t1++;
      end
      chk("volt again", 1, volt_mode_o);
      chk("resumed scale", held, pwm_scale_o);
      $display("test freeze done");
      // The open coil now holds the larger target, so full current is never reached.
      target_a_i <= 8'h82;
      target_b_i <= 8'h64;
      pulse_steps(6);
      cyc(2);
      chk("both flags", 2'b11, {coil_a_open_flag_o, coil_b_open_flag_o});
      $display("test full step done");
      // Interrupt status, mask and write-one-to-clear.
      rd(vps_pkg::ADDR_INT_ST, d);
      chk("events", 32'h7, d);
      chk("masked irq", 0, irq_o);
      wr(vps_pkg::ADDR_INT_MASK, 32'h0000_0002);
      cyc(2);
      chk("irq raised", 1, irq_o);
      rd(vps_pkg::ADDR_INT_MASK, d);
      chk("mask reg", mdl[6], d);
      wr(vps_pkg::ADDR_INT_ST, 32'h0000_0002);
      cyc(2);
      chk("irq cleared", 0, irq_o);
      rd(vps_pkg::ADDR_INT_ST, d);
      chk("events left", 32'h5, d);
      $display("test interrupt done");
      // Clock enable low must swallow a write; the model skips it as well.
      ce_i <= 1'b0;
      wr(vps_pkg::ADDR_INT_MASK, 32'h0000_0005);
      cyc(2);
      chk("frozen irq", 0, irq_o);
      ce_i <= 1'b1;
      rd(vps_pkg::ADDR_INT_MASK, d);
      chk("frozen mask", mdl[6], d);
      $display("test enable done");
      // Recovery after an unrecoverable state: clear all three interrupt flags with one write and read them back as zero.
      wr(vps_pkg::ADDR_INT_ST, 32'h0000_0007);
      rd(vps_pkg::ADDR_INT_ST, d);
      chk("events cleared", 0, d);
      $display("test recovery done");
      close_out();
   end
endmodule
